// file: common/sar_pkg.sv
// Package for the successive-approximation converter control block.
// Assumes a single 200 MHz system clock domain and a plain register port.
package sar_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h1f;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h9f;
  localparam logic [7:0] ADDR_RESULT = 8'h1e;
  localparam logic [7:0] ADDR_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_ENABLE = 8'h8c;
  localparam logic [7:0] ADDR_PORTA = 8'h05;
  localparam logic [7:0] ADDR_PORTE = 8'h09;
  localparam logic [7:0] ADDR_SYS = 8'h90;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ON_BIT = 0;
  localparam int GO_BIT = 2;
  localparam int CHS_LSB = 3;
  localparam int CKS_LSB = 6;
  localparam int DONE_BIT = 6;
  localparam int HALT_BIT = 0;
  localparam logic [7:0] MAIN_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET = 8'h00;
  localparam logic [7:0] MAIN_WMASK = 8'hfd;
  localparam logic [7:0] PIN_WMASK = 8'h07;
  localparam logic [1:0] CKS_RC = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CONV_PERIODS = 10;
  localparam int WAIT_PERIODS = 2;
  localparam int DIV_X2 = 2;
  localparam int DIV_X8 = 8;
  localparam int DIV_X32 = 32;
  localparam int CLK_MHZ = 200;
  localparam int INSTR_OSC = 4;
  typedef enum logic [1:0] {ST_SAMPLE, ST_DELAY, ST_CONVERT, ST_HOLDOFF} conv_state_t;
endpackage : sar_pkg

// file: hw/sar_converter_control.sv
// Control logic of an 8-bit successive-approximation converter.
// Assumes a comparator outside, register strobes synchronous to clk_sys.
`timescale 1ns/1ps

// Behaviour
// - Eight channels, one sample-hold, 8-bit result.
// - Channel select at main control bits 5:3.
// - Converter runs only while converter_on set.
// - Go starts; finish loads result, clears go, flags.
// - Done flag bit 6, enable bit 6 gates interrupt.
// - Conversion lasts exactly ten bit periods.
// - Bit period from osc x2/x8/x32 or RC.
// - Two bit periods hold-off after completion.
// - Pin config field sets analog pins, reference.
// - Analog pins read zero from port registers.
// - Direction and pin config bits never block conversion.
// - Converter keeps working during halt under the RC source.
// - Clock select codes 00/01/10/11; only RC in halt.
// - Clearing go aborts, result kept, hold-off, resample.
// - RC source delays start one instruction cycle.
module sar_converter_control #(
  parameter int RC_DIV = 800 // RC bit period in clk_sys cycles, 4 us typical
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic halt, // Device in low-power halt
  input wire logic cmp_in, // Comparator: input above trial level
  input wire logic [7:0] porta_pins, // Port A pin levels
  input wire logic [2:0] porte_pins, // Port E pin levels
  output logic [7:0] rdata, // Read data, cycle after strobe
  output logic irq, // Level interrupt
  output logic [2:0] chan_sel, // Analog mux channel
  output logic hold_connect, // Holding capacitor tied to channel
  output logic [7:0] dac_trial, // Trial code for comparator
  output logic conv_busy, // Conversion running
  output logic ref_ext, // External reference selected
  output logic [7:0] analog_pins, // Analog pin mask, 7:5 port E
  output logic conv_power // Converter powered
);
  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  // Two settling periods come before the first bit decision
  localparam logic [3:0] FIRST_BIT = 4'(sar_pkg::CONV_PERIODS - 8);
  localparam logic [3:0] LAST_CONV = 4'(sar_pkg::CONV_PERIODS - 1);
  localparam logic [3:0] LAST_WAIT = 4'(sar_pkg::WAIT_PERIODS - 1);
  localparam logic [2:0] LAST_INS = 3'(sar_pkg::INSTR_OSC - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Register state
  sar_pkg::conv_state_t state_r; // Sequencer state
  sar_pkg::conv_state_t state_nxt; // Next sequencer state
  logic [7:0] main_r; // Clock select, channel, go, on
  logic [7:0] pin_r; // Port configuration, bits 2:0 only
  logic [7:0] result_r; // Last completed or written result
  logic [7:0] trial_r; // Successive-approximation register
  logic [7:0] trial_nxt; // Trial code after this edge
  logic done_r; // Conversion complete flag
  logic irq_en_r; // Interrupt enable of the done flag
  logic irq_r; // Interrupt level
  logic [7:0] rdata_r; // Read data, one cycle after strobe
  // Registered copies of the outputs
  logic [2:0] chan_r;
  logic hold_r;
  logic busy_r;
  logic ref_r;
  logic [7:0] analog_r;
  logic power_r;
  // Timing
  logic [15:0] tad_cnt_r; // Clocks within the current bit period
  logic [15:0] tad_last; // Last count of a bit period
  logic [3:0] per_cnt_r; // Bit periods elapsed in this phase
  logic [2:0] ins_cnt_r; // Start delay under the RC source
  logic [15:0] conv_clk_r; // Clocks spent converting, for checks
  // Decodes
  logic [2:0] bit_idx;
  logic [7:0] amask;
  logic [7:0] rmask;
  logic [7:0] porta_zero;
  logic [2:0] porte_zero;
  logic tick;
  logic go;
  logic on;
  logic rc_sel;
  logic halt_abort;
  logic wr_main;
  logic wr_flag;
  logic wr_result;
  logic done_evt;
  logic abort_evt;

  // ----------------------------------------------------------------
  // Field decodes
  // ----------------------------------------------------------------
  // Control fields and write targets
  assign on = main_r[sar_pkg::ON_BIT];
  assign go = main_r[sar_pkg::GO_BIT];
  assign rc_sel = main_r[sar_pkg::CKS_LSB +: 2] == sar_pkg::CKS_RC;
  // Oscillator sources cannot run in halt; the RC source can
  assign halt_abort = halt && !rc_sel;
  assign wr_main = wr_en && (addr == sar_pkg::ADDR_MAIN_CTRL);
  assign wr_flag = wr_en && (addr == sar_pkg::ADDR_FLAG);
  assign wr_result = wr_en && (addr == sar_pkg::ADDR_RESULT);

  // Bit period length per clock source
  always_comb begin
    tad_last = 16'(sar_pkg::DIV_X2 - 1);
    unique case (main_r[sar_pkg::CKS_LSB +: 2])
      2'h0: tad_last = 16'(sar_pkg::DIV_X2 - 1);
      2'h1: tad_last = 16'(sar_pkg::DIV_X8 - 1);
      2'h2: tad_last = 16'(sar_pkg::DIV_X32 - 1);
      2'h3: tad_last = 16'(RC_DIV - 1);
    endcase
  end

  // A bit period ends; >= so a source change mid-period cannot hang
  assign tick = ((state_r == sar_pkg::ST_CONVERT) || (state_r == sar_pkg::ST_HOLDOFF))
                && (tad_cnt_r >= tad_last);

  // ----------------------------------------------------------------
  // Pin configuration
  // ----------------------------------------------------------------
  // Analog channel mask; odd codes give the reference pin away
  always_comb begin
    amask = 8'h00;
    case (pin_r[2:0])
      3'h0, 3'h1: amask = 8'hff;
      3'h2, 3'h3: amask = 8'h1f;
      3'h4, 3'h5: amask = 8'h0b;
      default: amask = 8'h00;
    endcase
    if (pin_r[0]) begin
      amask[3] = 1'b0;
    end
  end

  // Analog inputs and the reference pin read low
  assign rmask = amask | {4'h0, pin_r[0], 3'h0};
  assign porta_zero = {2'h0, rmask[4], 1'b0, rmask[3:0]};
  assign porte_zero = rmask[7:5];

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Pin direction and configuration bits never gate the sequencer
  always_comb begin
    state_nxt = state_r;
    done_evt = 1'b0;
    abort_evt = 1'b0;
    unique case (state_r)
      sar_pkg::ST_SAMPLE: begin
        if (on && go && !halt_abort) begin
          // RC source waits one instruction cycle first
          state_nxt = rc_sel ? sar_pkg::ST_DELAY : sar_pkg::ST_CONVERT;
        end
      end
      sar_pkg::ST_DELAY: begin
        if (!go || halt_abort) begin
          state_nxt = sar_pkg::ST_HOLDOFF;
          abort_evt = 1'b1;
        end else if (ins_cnt_r == LAST_INS) begin
          state_nxt = sar_pkg::ST_CONVERT;
        end
      end
      sar_pkg::ST_CONVERT: begin
        if (!go || halt_abort) begin
          state_nxt = sar_pkg::ST_HOLDOFF;
          abort_evt = 1'b1;
        end else if (tick && (per_cnt_r == LAST_CONV)) begin
          state_nxt = sar_pkg::ST_HOLDOFF;
          done_evt = 1'b1;
        end
      end
      sar_pkg::ST_HOLDOFF: begin
        if (tick && (per_cnt_r == LAST_WAIT)) begin
          state_nxt = sar_pkg::ST_SAMPLE;
        end
      end
    endcase
    // Turning the converter off drops any conversion at once
    if (!on) begin
      state_nxt = sar_pkg::ST_SAMPLE;
      done_evt = 1'b0;
      abort_evt = 1'b0;
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= sar_pkg::ST_SAMPLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit period and period counters, cleared on every state change
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tad_cnt_r <= 16'h0000;
      per_cnt_r <= 4'h0;
    end else if (state_nxt != state_r) begin
      tad_cnt_r <= 16'h0000;
      per_cnt_r <= 4'h0;
    end else if (tick) begin
      tad_cnt_r <= 16'h0000;
      per_cnt_r <= per_cnt_r + 4'h1;
    end else if ((state_r == sar_pkg::ST_CONVERT) || (state_r == sar_pkg::ST_HOLDOFF)) begin
      tad_cnt_r <= tad_cnt_r + 16'h0001;
    end
  end

  // Instruction-cycle delay under the RC source
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ins_cnt_r <= 3'h0;
    end else if (state_r == sar_pkg::ST_DELAY) begin
      ins_cnt_r <= ins_cnt_r + 3'h1;
    end else begin
      ins_cnt_r <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Successive approximation
  // ----------------------------------------------------------------
  // Bit under trial: 7 in the third period, 0 in the last
  assign bit_idx = 3'(LAST_CONV - per_cnt_r);

  // Keep the bit if the input is at or above the trial level
  always_comb begin
    trial_nxt = trial_r;
    if (tick && (state_r == sar_pkg::ST_CONVERT) && (per_cnt_r >= FIRST_BIT)) begin
      trial_nxt[bit_idx] = cmp_in;
      if (bit_idx != 3'h0) begin
        trial_nxt[bit_idx - 3'h1] = 1'b1;
      end
    end
  end

  // Trial register starts at mid-scale on entry to conversion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trial_r <= 8'h00;
    end else if ((state_r != sar_pkg::ST_CONVERT) && (state_nxt == sar_pkg::ST_CONVERT)) begin
      trial_r <= 8'h80;
    end else begin
      trial_r <= trial_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Main control; hardware clears go at completion or halt abort
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_r <= sar_pkg::MAIN_RESET;
    end else if (wr_main) begin
      main_r <= wdata & sar_pkg::MAIN_WMASK;
    end else if (done_evt || (abort_evt && halt_abort)) begin
      main_r[sar_pkg::GO_BIT] <= 1'b0;
    end
  end

  // Pin configuration
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_r <= sar_pkg::PIN_RESET;
    end else if (wr_en && (addr == sar_pkg::ADDR_PIN_CFG)) begin
      pin_r <= wdata & sar_pkg::PIN_WMASK;
    end
  end

  // Result; an aborted conversion leaves it untouched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_r <= 8'h00;
    end else if (done_evt) begin
      result_r <= trial_nxt;
    end else if (wr_result) begin
      result_r <= wdata;
    end
  end

  // Done flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (done_evt) begin
      done_r <= 1'b1;
    end else if (wr_flag && wdata[sar_pkg::DONE_BIT]) begin
      done_r <= 1'b0;
    end
  end

  // Interrupt enable and level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_en_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (wr_en && (addr == sar_pkg::ADDR_ENABLE)) begin
        irq_en_r <= wdata[sar_pkg::DONE_BIT];
      end
      irq_r <= done_r && irq_en_r;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        sar_pkg::ADDR_MAIN_CTRL: rdata_r <= main_r;
        sar_pkg::ADDR_PIN_CFG: rdata_r <= pin_r;
        sar_pkg::ADDR_RESULT: rdata_r <= result_r;
        sar_pkg::ADDR_FLAG: rdata_r <= {1'b0, done_r, 6'h00};
        sar_pkg::ADDR_ENABLE: rdata_r <= {1'b0, irq_en_r, 6'h00};
        sar_pkg::ADDR_PORTA: rdata_r <= porta_pins & ~porta_zero;
        sar_pkg::ADDR_PORTE: rdata_r <= {5'h00, porte_pins & ~porte_zero};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Hold and busy copies taken from next state so they line up with state_r
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_r <= 3'h0;
      hold_r <= 1'b0;
      busy_r <= 1'b0;
      ref_r <= 1'b0;
      analog_r <= 8'h00;
      power_r <= 1'b0;
    end else begin
      chan_r <= main_r[sar_pkg::CHS_LSB +: 3];
      hold_r <= on && ((state_nxt == sar_pkg::ST_SAMPLE)
                || (state_nxt == sar_pkg::ST_DELAY));
      busy_r <= (state_nxt == sar_pkg::ST_DELAY) || (state_nxt == sar_pkg::ST_CONVERT);
      ref_r <= pin_r[0];
      analog_r <= amask;
      power_r <= on && !halt_abort;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign chan_sel = chan_r;
  assign hold_connect = hold_r;
  assign dac_trial = trial_r;
  assign conv_busy = busy_r;
  assign ref_ext = ref_r;
  assign analog_pins = analog_r;
  assign conv_power = power_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Helper: clocks spent in conversion, independent of the counters
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_clk_r <= 16'h0000;
    end else if (state_r == sar_pkg::ST_CONVERT) begin
      conv_clk_r <= conv_clk_r + 16'h0001;
    end else begin
      conv_clk_r <= 16'h0000;
    end
  end

  a_done_updates: assert property (done_evt && !wr_main |=> done_r && !go)
    else $error("done flag set without go cleared");
  a_ten_periods: assert property (done_evt |->
    (32'(conv_clk_r) + 1) == (sar_pkg::CONV_PERIODS * (32'(tad_last) + 1)))
    else $error("conversion length is not ten bit periods");
  a_irq_level: assert property (1'b1 |=> irq == $past(done_r && irq_en_r))
    else $error("interrupt level does not follow flag and enable");
  a_off_idle: assert property (!on |=> (state_r == sar_pkg::ST_SAMPLE) && !conv_busy)
    else $error("sequencer active while converter off");
  a_holdoff_open: assert property ((state_r == sar_pkg::ST_HOLDOFF) |-> !hold_connect)
    else $error("holding capacitor connected during hold-off");
  a_abort_keeps: assert property (abort_evt && !wr_result |=> $stable(result_r))
    else $error("abort changed the result");
  a_analog_zero: assert property (rd_en && (addr == sar_pkg::ADDR_PORTA) |=>
    (rdata & $past(porta_zero)) == 8'h00)
    else $error("analog pin read back high");
  a_chan_follows: assert property (1'b1 |=> chan_sel == $past(main_r[5:3]))
    else $error("channel output does not follow select field");

  c_done: cover property (done_evt);
  c_abort: cover property (abort_evt);
  c_halt_rc: cover property (halt && rc_sel && (state_r == sar_pkg::ST_CONVERT));
  c_done_irq: cover property (done_evt && irq_en_r);
endmodule : sar_converter_control

// file: verif/analog_src.sv
// Analog source model: a fixed input level against the trial code.
// Assumes the block's comparator input follows this output.
`timescale 1ns/1ps
module analog_src #(parameter logic [7:0] LEVEL = 8'h5a) (
  input wire logic [7:0] trial, // Trial code
  output logic above // Level at or above trial
);
  assign above = LEVEL >= trial;
endmodule : analog_src

// file: verif/tb_sar_converter_control.sv
// Bench: register port, conversions, interrupt.
// Assumes the analog source model on the comparator.
`timescale 1ns/1ps
module tb_sar_converter_control;
  localparam int RC_DIV = 6; // Short RC bit period keeps the run brief
  localparam int LIMIT = 20000; // Cycle ceiling, over twenty times the run
  logic clk_sys, rst, wr_en, rd_en, halt, cmp_in, irq, hold_connect, conv_busy, ref_ext;
  logic conv_power;
  logic [7:0] addr, wdata, rdata, porta_pins, dac_trial, analog_pins, d;
  logic [2:0] porte_pins, chan_sel;
  int fail_count, samples_checked, cyc;
  sar_converter_control #(.RC_DIV(RC_DIV)) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .halt(halt),
    .cmp_in(cmp_in),
    .porta_pins(porta_pins),
    .porte_pins(porte_pins),
    .rdata(rdata),
    .irq(irq),
    .chan_sel(chan_sel),
    .hold_connect(hold_connect),
    .dac_trial(dac_trial),
    .conv_busy(conv_busy),
    .ref_ext(ref_ext),
    .analog_pins(analog_pins),
    .conv_power(conv_power)
  );
  analog_src src (.trial(dac_trial), .above(cmp_in));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task chk(string n, logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end
  endtask : chk
  // Gap cycle after each strobe, so no signal is set twice at one edge
  task wr(logic [7:0] a, v);
    @(posedge clk_sys) begin addr <= a; wdata <= v; wr_en <= 1; end
    @(posedge clk_sys) wr_en <= 0;
  endtask : wr
  task rd(logic [7:0] a);
    @(posedge clk_sys) begin addr <= a; rd_en <= 1; end
    @(posedge clk_sys) rd_en <= 0;
    #1 d = rdata;
  endtask : rd
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // One conversion with a given source, interrupt enable and halt level
  task t_conv(logic ie, logic [1:0] cks, logic hl);
    int per;
    per = (cks == 2'h0) ? 2 : (cks == 2'h1) ? 8 : (cks == 2'h2) ? 32 : RC_DIV;
    wr(8'h8c, {1'b0, ie, 6'h0}); halt <= hl;
    wr(8'h1f, {cks, 6'h01});
    repeat (40) @(posedge clk_sys);
    chk("power", {7'h0, conv_power}, 8'h01);
    chk("sampling", {7'h0, hold_connect}, 8'h01);
    wr(8'h1f, {cks, 6'h05});
    repeat (10 * per - 4) @(posedge clk_sys);
    rd(8'h1f); chk("early", d, {cks, 6'h05});
    chk("busy", {7'h0, conv_busy}, 8'h01);
    for (int i = 0; i < 200 && d[2]; i++) rd(8'h1f);
    chk("go", d, {cks, 6'h01});
    rd(8'h1e); chk("result", d, 8'h5a);
    rd(8'h0c); chk("flag", d, 8'h40);
    chk("irq", {7'h0, irq}, {7'h0, ie});
    wr(8'h0c, 8'h40); rd(8'h0c); chk("clear", d, 8'h00);
    halt <= 1'b0;
    $display("conversion test done");
  endtask : t_conv
  // Pin configuration codes, analog masks and port reads
  task t_pins;
    porta_pins <= 8'hff; porte_pins <= 3'h7;
    wr(8'h9f, 8'h04); rd(8'h05); chk("porta4", d, 8'hf4);
    rd(8'h09); chk("porte4", d, 8'h07);
    chk("mask4", analog_pins, 8'h0b);
    chk("ref4", {7'h0, ref_ext}, 8'h00);
    wr(8'h9f, 8'h01); rd(8'h05); chk("porta1", d, 8'hd0);
    rd(8'h09); chk("porte1", d, 8'h00);
    chk("mask1", analog_pins, 8'hf7);
    chk("ref1", {7'h0, ref_ext}, 8'h01);
    wr(8'h1f, 8'h28); repeat (2) @(posedge clk_sys);
    chk("chan", {5'h0, chan_sel}, 8'h05);
    wr(8'h1f, 8'h00); wr(8'h9f, 8'h00);
    $display("pin test done");
  endtask : t_pins
  // Abort by clearing go, then by halt under an oscillator source
  task t_abort;
    wr(8'h1f, 8'h81); repeat (40) @(posedge clk_sys);
    wr(8'h1f, 8'h85); repeat (50) @(posedge clk_sys);
    chk("abusy", {7'h0, conv_busy}, 8'h01);
    wr(8'h1f, 8'h81); repeat (2) @(posedge clk_sys);
    chk("ahold", {7'h0, hold_connect}, 8'h00);
    chk("aidle", {7'h0, conv_busy}, 8'h00);
    rd(8'h1e); chk("akeep", d, 8'h5a);
    rd(8'h0c); chk("aflag", d, 8'h00);
    repeat (80) @(posedge clk_sys);
    chk("aresample", {7'h0, hold_connect}, 8'h01);
    wr(8'h1f, 8'h85); repeat (50) @(posedge clk_sys);
    halt <= 1'b1; repeat (4) @(posedge clk_sys);
    rd(8'h1f); chk("hgo", d, 8'h81);
    chk("hpower", {7'h0, conv_power}, 8'h00);
    halt <= 1'b0;
    rd(8'h0c); chk("hflag", d, 8'h00);
    wr(8'h1f, 8'h00); repeat (80) @(posedge clk_sys);
    $display("abort test done");
  endtask : t_abort
  // Reset with the converter on returns main control and pin config to their reset values
  task t_reset;
    wr(8'h1f, 8'h01); wr(8'h9f, 8'h05);
    rst <= 1'b1; repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h1f); chk("rmain", d, 8'h00);
    rd(8'h9f); chk("rpin", d, 8'h00);
    chk("rpower", {7'h0, conv_power}, 8'h00);
    $display("reset test done");
  endtask : t_reset
  initial begin
    rst = 1; wr_en = 0; rd_en = 0; addr = 0; wdata = 0; halt = 0;
    porta_pins = 0; porte_pins = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    rd(8'h1f); chk("main", d, 8'h00);
    rd(8'h9f); chk("pincfg", d, 8'h00);
    rd(8'h33); chk("unmapped", d, 8'h00);
    t_pins;
    t_conv(1, 2'h0, 0); t_conv(0, 2'h1, 0); t_conv(1, 2'h3, 1);
    t_abort; t_reset; test_done;
  end
  always @(posedge clk_sys) if (++cyc == LIMIT) begin fail_count++; test_done; end
endmodule : tb_sar_converter_control
